//--- include/dscr_defines.vh
// Notes on behaviour
// - Hold 14-bit vertical active line count.
// - Hold 16-bit pixel limit for memory writes.
// - Split pixel data at that limit; a zero limit acts as one pixel.
// - Bit 24: max return size, 1=low-power.
// - Bit 19: command-set long write, 1=low-power.
// - Bit 18: command-set short read, 1=low-power.
// - Bits 17/16: command-set short writes, 1=low-power.
// - Bit 14: generic long write, 1=low-power.
// - Bits 13..11: generic short reads mode select.
// - Bits 10..8: generic short writes mode select.
// - Bit 0 requests tearing-effect acknowledge.
// - Header 23:16 count high or data two.
// - Header 15:8 count low or data one.
// - Header 7:6 is virtual channel.
// - Header 5:0 is packet data type.
// - Payload bytes one..four in low..high lanes.
// - Read busy set on read, cleared when stored.
// - Command FIFO full/empty in status bits 1/0.
`ifndef DSCR_DEFINES_VH
`define DSCR_DEFINES_VH

`define DSCR_ADDR_VACTIVE 12'h060
`define DSCR_ADDR_MWSIZE 12'h064
`define DSCR_ADDR_CMDCFG 12'h068
`define DSCR_ADDR_HEADER 12'h06c
`define DSCR_ADDR_PAYLOAD 12'h070
`define DSCR_ADDR_STATUS 12'h074

`define DSCR_VACTIVE_W 14
`define DSCR_MWSIZE_W 16
`define DSCR_HEADER_W 24
`define DSCR_RST_VACTIVE 14'h0000
`define DSCR_RST_MWSIZE 16'h0000
`define DSCR_RST_CMDCFG 32'h00000000
`define DSCR_CMDCFG_MASK 32'h010f7f03

`define DSCR_CFG_MAXRET 24
`define DSCR_CFG_CS_LW 19
`define DSCR_CFG_CS_SR0 18
`define DSCR_CFG_CS_SW1 17
`define DSCR_CFG_CS_SW0 16
`define DSCR_CFG_GEN_LW 14
`define DSCR_CFG_GEN_SR2 13
`define DSCR_CFG_GEN_SR1 12
`define DSCR_CFG_GEN_SR0 11
`define DSCR_CFG_GEN_SW2 10
`define DSCR_CFG_GEN_SW1 9
`define DSCR_CFG_GEN_SW0 8
`define DSCR_CFG_ACK_REQ 1
`define DSCR_CFG_TEAR_REQ 0

`define DSCR_ST_RD_BUSY 6
`define DSCR_ST_RPLD_FULL 5
`define DSCR_ST_RPLD_EMPTY 4
`define DSCR_ST_WPLD_FULL 3
`define DSCR_ST_WPLD_EMPTY 2
`define DSCR_ST_CMD_FULL 1
`define DSCR_ST_CMD_EMPTY 0

`define DSCR_DT_GEN_SW0 6'h03
`define DSCR_DT_GEN_SW1 6'h13
`define DSCR_DT_GEN_SW2 6'h23
`define DSCR_DT_GEN_SR0 6'h04
`define DSCR_DT_GEN_SR1 6'h14
`define DSCR_DT_GEN_SR2 6'h24
`define DSCR_DT_GEN_LW 6'h29
`define DSCR_DT_CS_SW0 6'h05
`define DSCR_DT_CS_SW1 6'h15
`define DSCR_DT_CS_SR0 6'h06
`define DSCR_DT_CS_LW 6'h39
`define DSCR_DT_MAXRET 6'h37

`endif

//--- design/dscr_fifo.v
`timescale 1ns/1ps
module dscr_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH_LOG2 = 4
) (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // Fill side.
    input wire wrValid,
    output wire wrReady,
    input wire [WIDTH-1:0] wrData,
    // Drain side.
    output wire rdValid,
    input wire rdReady,
    output wire [WIDTH-1:0] rdData,
    // Status.
    output wire full,
    output wire empty
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [DEPTH_LOG2-1:0] wrPtr;
    reg [DEPTH_LOG2-1:0] rdPtr;
    reg [DEPTH_LOG2:0] count;
    wire doWrite;
    wire doRead;

    assign full = (count == DEPTH[DEPTH_LOG2:0]);
    assign empty = (count == {(DEPTH_LOG2+1){1'b0}});
    assign wrReady = !full;
    assign rdValid = !empty;
    assign rdData = mem[rdPtr];
    assign doWrite = wrValid && !full;
    assign doRead = rdReady && !empty;

    always @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr] <= wrData;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr <= {DEPTH_LOG2{1'b0}};
            rdPtr <= {DEPTH_LOG2{1'b0}};
            count <= {(DEPTH_LOG2+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // dscr_fifo

//--- design/dscr_mw_split.v
`timescale 1ns/1ps
`include "dscr_defines.vh"
module dscr_mw_split #(
    parameter PIX_W = 24
) (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // Largest memory write in pixels.
    input wire [`DSCR_MWSIZE_W-1:0] sizeLimit,
    // Pixel port.
    input wire pixValid,
    output wire pixReady,
    input wire [PIX_W-1:0] pixData,
    input wire pixLast,
    // Segmented memory-write stream.
    output reg mwValid,
    input wire mwReady,
    output reg [PIX_W-1:0] mwData,
    output reg mwFirst,
    output reg mwLast
);
    reg [`DSCR_MWSIZE_W-1:0] count;
    wire [`DSCR_MWSIZE_W-1:0] limitEff;
    wire take;
    wire segEnd;

    // A zero limit is treated as one pixel per command.
    assign limitEff = (sizeLimit == {`DSCR_MWSIZE_W{1'b0}}) ? {{(`DSCR_MWSIZE_W-1){1'b0}}, 1'b1} : sizeLimit;
    assign pixReady = !mwValid || mwReady;
    assign take = pixValid && pixReady;
    assign segEnd = pixLast || (count == limitEff - 1'b1);

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= {`DSCR_MWSIZE_W{1'b0}};
            mwValid <= 1'b0;
            mwData <= {PIX_W{1'b0}};
            mwFirst <= 1'b0;
            mwLast <= 1'b0;
        end else begin
            if (take) begin
                mwValid <= 1'b1;
                mwData <= pixData;
                mwFirst <= (count == {`DSCR_MWSIZE_W{1'b0}});
                mwLast <= segEnd;
                count <= segEnd ? {`DSCR_MWSIZE_W{1'b0}} : count + 1'b1;
            end else if (mwReady) begin
                mwValid <= 1'b0;
            end
        end
    end
endmodule // dscr_mw_split

//--- design/dscr_cmd_regs.v
`timescale 1ns/1ps
`include "dscr_defines.vh"
module dscr_cmd_regs #(
    parameter PIX_W = 24,
    parameter CMD_DEPTH_LOG2 = 4,
    parameter PLD_DEPTH_LOG2 = 5
) (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Frame timing and link configuration.
    output wire [`DSCR_VACTIVE_W-1:0] vActiveLines,
    output wire tearingAckRequestEnable,
    // Generic command towards the packet builder.
    output wire cmdValid,
    input wire cmdReady,
    output wire [`DSCR_HEADER_W-1:0] cmdHeader,
    output wire cmdLowPower,
    output wire cmdAckRequest,
    // Generic write payload towards the packet builder.
    output wire wpldValid,
    input wire wpldReady,
    output wire [31:0] wpldData,
    // Generic read payload from the receiver.
    input wire rpldValid,
    output wire rpldReady,
    input wire [31:0] rpldData,
    input wire rspDone,
    // Pixel port and its memory-write segments.
    input wire pixValid,
    output wire pixReady,
    input wire [PIX_W-1:0] pixData,
    input wire pixLast,
    output wire mwValid,
    input wire mwReady,
    output wire [PIX_W-1:0] mwData,
    output wire mwFirst,
    output wire mwLast,
    output wire mwLowPower
);
    reg [`DSCR_VACTIVE_W-1:0] vActive;
    reg [`DSCR_MWSIZE_W-1:0] mwSize;
    reg [31:0] cmdCfg;
    reg readBusy;
    reg [31:0] next_prdata;
    reg addrHit;

    wire setupPhase;
    wire accessPhase;
    wire wrAccess;
    wire rdAccess;
    wire hdrPush;
    wire pldPush;
    wire pldPop;
    wire cmdFull;
    wire cmdEmpty;
    wire wpFull;
    wire wpEmpty;
    wire rpFull;
    wire rpEmpty;
    wire rpValid;
    wire [31:0] rpData;
    wire [5:0] cmdType;
    wire [31:0] statusWord;

    wire selVactive;
    wire selMwSize;
    wire selCmdCfg;
    wire selHeader;
    wire selPayload;
    wire selStatus;

    wire refuseUnmapped;
    wire refuseHeader;
    wire refusePayload;
    wire refuseStatus;
    reg popArmed;

    // Transmission mode for a data type: 1 selects low-power.
    function lowPowerFor;
        input [5:0] dt;
        input [31:0] cfg;
        begin
            case (dt)
                `DSCR_DT_MAXRET: lowPowerFor = cfg[`DSCR_CFG_MAXRET];
                `DSCR_DT_CS_LW: lowPowerFor = cfg[`DSCR_CFG_CS_LW];
                `DSCR_DT_CS_SR0: lowPowerFor = cfg[`DSCR_CFG_CS_SR0];
                `DSCR_DT_CS_SW1: lowPowerFor = cfg[`DSCR_CFG_CS_SW1];
                `DSCR_DT_CS_SW0: lowPowerFor = cfg[`DSCR_CFG_CS_SW0];
                `DSCR_DT_GEN_LW: lowPowerFor = cfg[`DSCR_CFG_GEN_LW];
                `DSCR_DT_GEN_SR2: lowPowerFor = cfg[`DSCR_CFG_GEN_SR2];
                `DSCR_DT_GEN_SR1: lowPowerFor = cfg[`DSCR_CFG_GEN_SR1];
                `DSCR_DT_GEN_SR0: lowPowerFor = cfg[`DSCR_CFG_GEN_SR0];
                `DSCR_DT_GEN_SW2: lowPowerFor = cfg[`DSCR_CFG_GEN_SW2];
                `DSCR_DT_GEN_SW1: lowPowerFor = cfg[`DSCR_CFG_GEN_SW1];
                `DSCR_DT_GEN_SW0: lowPowerFor = cfg[`DSCR_CFG_GEN_SW0];
                default: lowPowerFor = 1'b0;
            endcase
        end
    endfunction

    // Commands that expect a response from the panel.
    function isReadType;
        input [5:0] dt;
        begin
            isReadType = (dt == `DSCR_DT_GEN_SR0) ||
                         (dt == `DSCR_DT_GEN_SR1) ||
                         (dt == `DSCR_DT_GEN_SR2) ||
                         (dt == `DSCR_DT_CS_SR0);
        end
    endfunction

    // APB phases; every transfer completes with no wait state.
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAccess = accessPhase && pwrite;
    assign rdAccess = accessPhase && !pwrite;
    assign pready = 1'b1;

    assign selVactive = (paddr == `DSCR_ADDR_VACTIVE);
    assign selMwSize = (paddr == `DSCR_ADDR_MWSIZE);
    assign selCmdCfg = (paddr == `DSCR_ADDR_CMDCFG);
    assign selHeader = (paddr == `DSCR_ADDR_HEADER);
    assign selPayload = (paddr == `DSCR_ADDR_PAYLOAD);
    assign selStatus = (paddr == `DSCR_ADDR_STATUS);

    // Header writes queue a command; payload writes and reads move FIFO words.
    // A payload read pops only the word it returned, so a word that lands between
    // the setup and access phases of a read that found the FIFO empty is kept.
    assign hdrPush = wrAccess && selHeader && !cmdFull;
    assign pldPush = wrAccess && selPayload && !wpFull;
    assign pldPop = rdAccess && selPayload && popArmed;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            popArmed <= 1'b0;
        end else if (setupPhase) begin
            popArmed <= !pwrite && selPayload && rpValid;
        end
    end

    // Unmapped addresses, writes into a full FIFO and status writes are refused.
    assign refuseUnmapped = !addrHit;
    assign refuseHeader = pwrite && selHeader && cmdFull;
    assign refusePayload = pwrite && selPayload && wpFull;
    assign refuseStatus = pwrite && selStatus;
    assign pslverr = accessPhase &&
                     (refuseUnmapped || refuseHeader || refusePayload || refuseStatus);

    always @* begin
        case (paddr)
            `DSCR_ADDR_VACTIVE,
            `DSCR_ADDR_MWSIZE,
            `DSCR_ADDR_CMDCFG,
            `DSCR_ADDR_HEADER,
            `DSCR_ADDR_PAYLOAD,
            `DSCR_ADDR_STATUS: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end

    assign statusWord = {25'h0000000,
                         readBusy,
                         rpFull,
                         rpEmpty,
                         wpFull,
                         wpEmpty,
                         cmdFull,
                         cmdEmpty};

    // The header register is write-only in effect: reads return zero.
    always @* begin
        case (paddr)
            `DSCR_ADDR_VACTIVE: next_prdata = {18'h00000, vActive};
            `DSCR_ADDR_MWSIZE: next_prdata = {16'h0000, mwSize};
            `DSCR_ADDR_CMDCFG: next_prdata = cmdCfg;
            `DSCR_ADDR_HEADER: next_prdata = 32'h00000000;
            `DSCR_ADDR_PAYLOAD: next_prdata = rpValid ? rpData : 32'h00000000;
            `DSCR_ADDR_STATUS: next_prdata = statusWord;
            default: next_prdata = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup phase and stands through the access phase.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (setupPhase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Configuration writes; reserved bits always read back as zero.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vActive <= `DSCR_RST_VACTIVE;
            mwSize <= `DSCR_RST_MWSIZE;
            cmdCfg <= `DSCR_RST_CMDCFG;
        end else if (wrAccess) begin
            case (paddr)
                `DSCR_ADDR_VACTIVE: vActive <= pwdata[`DSCR_VACTIVE_W-1:0];
                `DSCR_ADDR_MWSIZE: mwSize <= pwdata[`DSCR_MWSIZE_W-1:0];
                `DSCR_ADDR_CMDCFG: cmdCfg <= pwdata & `DSCR_CMDCFG_MASK;
                default: cmdCfg <= cmdCfg;
            endcase
        end
    end

    // Busy from a read leaving for the panel until its response is stored.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            readBusy <= 1'b0;
        end else if (cmdValid && cmdReady && isReadType(cmdType)) begin
            readBusy <= 1'b1;
        end else if (rspDone) begin
            readBusy <= 1'b0;
        end
    end

    assign vActiveLines = vActive;
    assign tearingAckRequestEnable = cmdCfg[`DSCR_CFG_TEAR_REQ];
    assign cmdAckRequest = cmdCfg[`DSCR_CFG_ACK_REQ];
    assign cmdType = cmdHeader[5:0];
    assign cmdLowPower = lowPowerFor(cmdType, cmdCfg);
    assign mwLowPower = cmdCfg[`DSCR_CFG_CS_LW];

    // Header layout: 23:16 count high, 15:8 count low, 7:6 channel, 5:0 type.
    dscr_fifo #(
        .WIDTH(`DSCR_HEADER_W),
        .DEPTH_LOG2(CMD_DEPTH_LOG2)
    ) cmdFifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wrValid(hdrPush),
        .wrReady(),
        .wrData(pwdata[`DSCR_HEADER_W-1:0]),
        .rdValid(cmdValid),
        .rdReady(cmdReady),
        .rdData(cmdHeader),
        .full(cmdFull),
        .empty(cmdEmpty)
    );

    // Write payload words wait here for the packet builder.
    dscr_fifo #(
        .WIDTH(32),
        .DEPTH_LOG2(PLD_DEPTH_LOG2)
    ) wpldFifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wrValid(pldPush),
        .wrReady(),
        .wrData(pwdata),
        .rdValid(wpldValid),
        .rdReady(wpldReady),
        .rdData(wpldData),
        .full(wpFull),
        .empty(wpEmpty)
    );

    // Read response words wait here until software fetches them.
    dscr_fifo #(
        .WIDTH(32),
        .DEPTH_LOG2(PLD_DEPTH_LOG2)
    ) rpldFifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wrValid(rpldValid),
        .wrReady(rpldReady),
        .wrData(rpldData),
        .rdValid(rpValid),
        .rdReady(pldPop),
        .rdData(rpData),
        .full(rpFull),
        .empty(rpEmpty)
    );

    // Pixel data cut into memory writes no longer than the limit (one pixel when the limit is zero).
    dscr_mw_split #(
        .PIX_W(PIX_W)
    ) mwSplit (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sizeLimit(mwSize),
        .pixValid(pixValid),
        .pixReady(pixReady),
        .pixData(pixData),
        .pixLast(pixLast),
        .mwValid(mwValid),
        .mwReady(mwReady),
        .mwData(mwData),
        .mwFirst(mwFirst),
        .mwLast(mwLast)
    );
endmodule // dscr_cmd_regs

//--- dv/dscr_cmd_regs_asserts.sv
`timescale 1ns/1ps
module dscr_cmd_regs_chk (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    // Configuration outputs.
    input wire [13:0] vActiveLines,
    input wire tearingAckRequestEnable,
    input wire cmdAckRequest,
    input wire mwLowPower,
    // Command and payload streams.
    input wire cmdValid,
    input wire [23:0] cmdHeader,
    input wire cmdLowPower,
    input wire wpldValid,
    input wire [31:0] wpldData,
    // Memory-write segments.
    input wire mwValid,
    input wire mwReady,
    input wire mwFirst,
    input wire mwLast
);
    wire wr = psel & penable & pwrite;
    reg [31:0] cfg;
    reg [31:0] pwPrev;
    reg [15:0] lim;
    reg [15:0] seg;
    wire [15:0] limEff = (lim == 16'h0) ? 16'h1 : lim;
    // Shadow copies of the configuration and of the segment position.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= 32'h0;
            lim <= 16'h0;
            seg <= 16'h0;
        end else begin
            if (wr && paddr == 12'h068) cfg <= pwdata & 32'h010f7f03;
            if (wr && paddr == 12'h064) lim <= pwdata[15:0];
            if (mwValid && mwReady) seg <= mwLast ? 16'h0 : seg + 16'h1;
        end
    end
    always @(posedge ref_clk) begin
        pwPrev <= pwdata;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_vact_load: assert property (wr && paddr == 12'h060 |=> vActiveLines == pwPrev[13:0])
        else $error("vertical line count not loaded");
    a_tear_load: assert property (wr && paddr == 12'h068 |=> tearingAckRequestEnable == pwPrev[0])
        else $error("tearing request enable wrong");
    a_ack_load: assert property (wr && paddr == 12'h068 |=> cmdAckRequest == pwPrev[1])
        else $error("acknowledge request enable wrong");
    a_mw_lowpower: assert property (mwLowPower == cfg[19])
        else $error("memory write mode wrong");
    a_maxret_mode: assert property (cmdValid && cmdHeader[5:0] == 6'h37 |-> cmdLowPower == cfg[24])
        else $error("max return size mode wrong");
    a_genlw_mode: assert property (cmdValid && cmdHeader[5:0] == 6'h29 |-> cmdLowPower == cfg[14])
        else $error("generic long write mode wrong");
    a_header_push: assert property (wr && paddr == 12'h06c && !pslverr && !cmdValid
        |=> cmdValid && cmdHeader == pwPrev[23:0]) else $error("header not queued");
    a_payload_push: assert property (wr && paddr == 12'h070 && !pslverr && !wpldValid
        |=> wpldValid && wpldData == pwPrev) else $error("payload not queued");
    a_seg_limit: assert property (mwValid |-> (mwLast || seg + 16'h1 < limEff) && mwFirst == (seg == 16'h0))
        else $error("segment boundary wrong");
    a_status_ro: assert property (wr && paddr == 12'h074 |-> pslverr)
        else $error("status write not refused");
endmodule // dscr_cmd_regs_chk
bind dscr_cmd_regs dscr_cmd_regs_chk u_chk (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pslverr, .vActiveLines, .tearingAckRequestEnable, .cmdAckRequest, .mwLowPower, .cmdValid, .cmdHeader,
    .cmdLowPower, .wpldValid, .wpldData, .mwValid, .mwReady, .mwFirst, .mwLast);

//--- dv/dscr_link_model.sv
`timescale 1ns/1ps
module dscr_link_model (
    // Clock, reset and stall control.
    input wire ref_clk,
    input wire sys_rst,
    input wire hold,
    // Command and write payload sinks.
    input wire cmdValid,
    output reg cmdReady,
    input wire [23:0] cmdHeader,
    output reg wpldReady,
    // Read response source.
    output reg rpldValid,
    input wire rpldReady,
    output reg [31:0] rpldData,
    output reg rspDone,
    // Memory-write sink.
    output reg mwReady
);
    reg [31:0] lf;
    reg [3:0] dly;
    reg [23:0] hdr;
    wire isRead = cmdHeader[1:0] == 2'b00 || cmdHeader[5:0] == 6'h06;
    // A read command is answered with one word ten cycles later, then the response is closed.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmdReady <= 1'b0;
            wpldReady <= 1'b0;
            rpldValid <= 1'b0;
            rpldData <= 32'h5a5a5a5a;
            rspDone <= 1'b0;
            mwReady <= 1'b0;
            lf <= 32'h1d;
            dly <= 4'h0;
            hdr <= 24'h0;
        end else begin
            lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
            mwReady <= lf[0] | lf[3];
            cmdReady <= !hold;
            wpldReady <= !hold;
            rspDone <= 1'b0;
            if (cmdValid && cmdReady && isRead) begin
                hdr <= cmdHeader;
                dly <= 4'ha;
            end else if (dly != 4'h0) begin
                dly <= dly - 4'h1;
            end
            if (dly == 4'h1) begin
                rpldValid <= 1'b1;
                rpldData <= {8'ha5, hdr};
            end
            if (rpldValid && rpldReady) begin
                rpldValid <= 1'b0;
                rpldData <= ~rpldData;
                rspDone <= 1'b1;
            end
        end
    end
endmodule // dscr_link_model

//--- dv/dscr_cmd_regs_tb.sv
`timescale 1ns/1ps
module dscr_cmd_regs_tb;
    reg ref_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b1;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    reg pixValid = 1'b0, pixLast = 1'b0;
    reg [23:0] pixData = 24'h0;
    wire [31:0] prdata, wpldData, rpldData;
    wire [23:0] cmdHeader, mwData;
    wire [13:0] vActiveLines;
    wire pslverr, pready, tearingAckRequestEnable, cmdValid, cmdReady, cmdLowPower, cmdAckRequest, wpldValid, wpldReady;
    wire rpldValid, rpldReady, rspDone, pixReady, mwValid, mwReady, mwFirst, mwLast, mwLowPower;
    localparam logic [5:0] DTS [12] = '{6'h03, 6'h13, 6'h23, 6'h04, 6'h14, 6'h24, 6'h29, 6'h05, 6'h15, 6'h06,
        6'h39, 6'h37};
    localparam int BITS [12] = '{8, 9, 10, 11, 12, 13, 14, 16, 17, 18, 19, 24};
    integer fails = 0, n_compared = 0, i, j, k, n, cnt, lim;
    reg [31:0] rnd = 32'h47, rdat, mexp, w0;
    reg [23:0] hdr;
    reg err;
    reg [25:0] q[$];
    always #10 ref_clk = ~ref_clk;
    dscr_cmd_regs DUT (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .vActiveLines, .tearingAckRequestEnable, .cmdValid, .cmdReady, .cmdHeader, .cmdLowPower,
        .cmdAckRequest, .wpldValid, .wpldReady, .wpldData, .rpldValid, .rpldReady, .rpldData, .rspDone,
        .pixValid, .pixReady, .pixData, .pixLast, .mwValid, .mwReady, .mwData, .mwFirst, .mwLast, .mwLowPower);
    dscr_link_model u_link (.ref_clk, .sys_rst, .hold, .cmdValid, .cmdReady, .cmdHeader, .wpldReady,
        .rpldValid, .rpldReady, .rpldData, .rspDone, .mwReady);
    function [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function lpOf(input int t, input [31:0] c);
        lpOf = c[BITS[t]];
    endfunction
    task chk(input string nm, input [31:0] seen, input [31:0] ex);
        n_compared++;
        if (seen !== ex) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task hang;
        fails++;
        stop_test;
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (n >= 8) hang;
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task psend(input [23:0] d, input l);
        pixValid <= 1'b1;
        pixData <= d;
        pixLast <= l;
        q.push_back({cnt == 0, cnt + 1 >= lim || l, d});
        cnt = (cnt + 1 >= lim || l) ? 0 : cnt + 1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pixReady !== 1'b1 && k < 50);
        if (k >= 50) hang;
    endtask
    always @(posedge ref_clk) begin
        if (mwValid === 1'b1 && mwReady === 1'b1) begin
            mexp = q.pop_front();
            chk("segment", {6'h0, mwFirst, mwLast, mwData}, mexp);
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            apb(1'b0, 12'h060 + 12'(4 * i), 32'h0);
            chk("reset value", rdat, (i == 5) ? 32'h15 : 32'h0);
        end
        apb(1'b1, 12'h100, 32'h1);
        chk("unmapped error", err, 1);
        apb(1'b1, 12'h074, 32'hffffffff);
        chk("status write error", err, 1);
        for (i = 0; i < 8; i++) begin
            rnd = (i == 0) ? 32'hffffffff : nx(rnd);
            apb(1'b1, 12'h060, rnd);
            apb(1'b0, 12'h060, 32'h0);
            chk("vactive", rdat, rnd & 32'h3fff);
            chk("vactive port", vActiveLines, rnd[13:0]);
            apb(1'b1, 12'h064, rnd);
            apb(1'b0, 12'h064, 32'h0);
            chk("size limit", rdat, rnd & 32'hffff);
            apb(1'b1, 12'h068, rnd);
            apb(1'b0, 12'h068, 32'h0);
            chk("mode config", rdat, rnd & 32'h010f7f03);
            chk("tearing", tearingAckRequestEnable, rnd[0]);
            chk("ack request", cmdAckRequest, rnd[1]);
            chk("mw mode", mwLowPower, rnd[19]);
        end
        for (i = 0; i < 12; i++) begin
            rnd = nx(rnd);
            hdr = {rnd[23:6], DTS[i]};
            apb(1'b1, 12'h068, rnd);
            apb(1'b1, 12'h06c, {rnd[31:24], hdr});
            @(posedge ref_clk);
            chk("header", cmdHeader, hdr);
            chk("type mode", cmdLowPower, lpOf(i, rnd));
            hold <= 1'b0;
            repeat (3) @(posedge ref_clk);
            if (DTS[i][1:0] == 2'b00 || DTS[i] == 6'h06) begin
                apb(1'b0, 12'h074, 32'h0);
                chk("read busy", rdat[6], 1);
                k = 0;
                do begin
                    apb(1'b0, 12'h074, 32'h0);
                    k++;
                end while (rdat[6] !== 1'b0 && k < 20);
                if (k >= 20) hang;
                apb(1'b0, 12'h070, 32'h0);
                chk("read payload", rdat, {8'ha5, hdr});
                apb(1'b0, 12'h070, 32'h0);
                chk("empty payload", rdat, 32'h0);
            end
            hold <= 1'b1;
        end
        for (i = 0; i < 33; i++) begin
            rnd = nx(rnd);
            if (i == 0) w0 = rnd;
            apb(1'b1, 12'h070, rnd);
            chk("payload refused", err, i == 32);
            if (i < 17) apb(1'b1, 12'h06c, {rnd[23:6], 6'h03});
            if (i < 17) chk("header refused", err, i == 16);
        end
        chk("payload head", wpldData, w0);
        apb(1'b0, 12'h074, 32'h0);
        chk("full status", rdat, 32'h1a);
        hold <= 1'b0;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while ((cmdValid !== 1'b0 || wpldValid !== 1'b0) && k < 200);
        if (k >= 200) hang;
        apb(1'b0, 12'h074, 32'h0);
        chk("drained status", rdat, 32'h15);
        for (j = 0; j < 5; j++) begin
            rnd = nx(rnd);
            lim = (j == 0) ? 0 : rnd[1:0] + 1;
            apb(1'b1, 12'h064, lim);
            if (lim == 0) lim = 1;
            cnt = 0;
            for (i = 0; i < 7; i++) begin
                rnd = nx(rnd);
                psend(rnd[23:0], i == 6);
            end
            pixValid <= 1'b0;
            k = 0;
            while (q.size() != 0 && k < 100) begin
                @(posedge ref_clk);
                k++;
            end
            if (k >= 100) hang;
        end
        stop_test;
    end
endmodule // dscr_cmd_regs_tb
